// ### hw/paa_allocator.sv
// Periphery address allocator with process image front end.
`timescale 1ns/100ps
module paa_allocator
  import paa_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic arst_n,
  // Allocation control.
  input wire logic start,
  input wire logic userCfgValid,
  input wire logic [SLOT_W-1:0] moduleCount,
  input wire logic [ADDR_W-1:0] imageLastCfg,
  input wire logic imageLastLoad,
  // Slot description request and answer.
  output logic [SLOT_W-1:0] slotIdx,
  input wire paa_class_t slotClass,
  input wire logic [SIZE_W-1:0] slotInSize,
  input wire logic [SIZE_W-1:0] slotOutSize,
  input wire logic [ADDR_W-1:0] userInAddr,
  input wire logic [ADDR_W-1:0] userOutAddr,
  // Allocation results.
  output logic resultValid,
  output logic [SLOT_W-1:0] resultSlot,
  output logic [ADDR_W-1:0] resultInAddr,
  output logic [ADDR_W-1:0] resultOutAddr,
  output logic allocDone,
  output logic allocError,
  // Program cycle and software access.
  input wire logic cycleEnd,
  input wire logic swWe,
  input wire logic swOut,
  input wire logic [IMAGE_IDX_W-1:0] swIdx,
  input wire logic [7:0] swWdata,
  output logic [7:0] swRdata,
  output logic refreshBusy,
  // Periphery byte port for refresh.
  output logic [IMAGE_IDX_W-1:0] periIdx,
  input wire logic [7:0] periInData,
  output logic [7:0] periOutData,
  output logic periOutWe
);
  paa_state_t state_r;
  logic [SLOT_W-1:0] slot_r;
  logic [ADDR_W-1:0] digIn_r;
  logic [ADDR_W-1:0] digOut_r;
  logic [ADDR_W-1:0] othIn_r;
  logic [ADDR_W-1:0] othOut_r;
  logic digInOver_r;
  logic digOutOver_r;
  logic [ADDR_W-1:0] imageLast_r;
  logic [ADDR_W-1:0] inBase;
  logic [ADDR_W-1:0] outBase;
  logic useOthIn;
  logic useOthOut;
  logic [ADDR_W-1:0] othInAligned;
  logic [ADDR_W-1:0] othOutAligned;
  logic [7:0] periInSync1_r;
  logic [7:0] periInSync2_r;
  paa_image_if img ();

  // Rounds an address up to the next even value.
  function automatic logic [ADDR_W-1:0] evenUp(input logic [ADDR_W-1:0] a);
    evenUp = a + {{(ADDR_W-1){1'b0}}, a[0]};
  endfunction : evenUp

  // Tells whether a digital span would pass the shared area boundary.
  function automatic logic passesBoundary(input logic [ADDR_W-1:0] p,
                                          input logic [SIZE_W-1:0] s);
    passesBoundary = (p + {8'h00, s}) > OTHER_BASE;
  endfunction : passesBoundary

  // Placement decision for the slot being handled.
  always_comb begin
    othInAligned = (slotClass == CLS_ANALOG) ? evenUp(othIn_r) : othIn_r;
    othOutAligned = (slotClass == CLS_ANALOG) ? evenUp(othOut_r) : othOut_r;
    useOthIn = (slotClass != CLS_DIGITAL) || digInOver_r
      || passesBoundary(digIn_r, slotInSize);
    useOthOut = (slotClass != CLS_DIGITAL) || digOutOver_r
      || passesBoundary(digOut_r, slotOutSize);
    inBase = useOthIn ? othInAligned : digIn_r;
    outBase = useOthOut ? othOutAligned : digOut_r;
    if (userCfgValid) begin
      inBase = userInAddr;
      outBase = userOutAddr;
    end
  end

  // Allocation sequencer over the plugged slots.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= ST_IDLE;
      slot_r <= FIRST_SLOT;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (start) begin
            slot_r <= FIRST_SLOT;
            state_r <= (moduleCount > MAX_MODULES) ? ST_ERROR : ST_FETCH;
          end
        end
        ST_FETCH: begin
          state_r <= (slot_r > moduleCount) ? ST_DONE : ST_PLACE;
        end
        ST_PLACE: begin
          slot_r <= slot_r + 7'h01;
          state_r <= ST_FETCH;
        end
        ST_DONE, ST_ERROR: begin
          if (start) begin
            slot_r <= FIRST_SLOT;
            state_r <= (moduleCount > MAX_MODULES) ? ST_ERROR : ST_FETCH;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Four running pointers, advanced by each span placed without user configuration.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      digIn_r <= DIGITAL_BASE;
      digOut_r <= DIGITAL_BASE;
      othIn_r <= OTHER_BASE;
      othOut_r <= OTHER_BASE;
      digInOver_r <= 1'b0;
      digOutOver_r <= 1'b0;
    end else if (start && state_r != ST_FETCH && state_r != ST_PLACE) begin
      digIn_r <= DIGITAL_BASE;
      digOut_r <= DIGITAL_BASE;
      othIn_r <= OTHER_BASE;
      othOut_r <= OTHER_BASE;
      digInOver_r <= 1'b0;
      digOutOver_r <= 1'b0;
    end else if (state_r == ST_PLACE && !userCfgValid) begin
      if (slotInSize != 8'h00) begin
        if (useOthIn) begin
          othIn_r <= othInAligned + {8'h00, slotInSize};
          digInOver_r <= digInOver_r || (slotClass == CLS_DIGITAL);
        end else begin
          digIn_r <= digIn_r + {8'h00, slotInSize};
        end
      end
      if (slotOutSize != 8'h00) begin
        if (useOthOut) begin
          othOut_r <= othOutAligned + {8'h00, slotOutSize};
          digOutOver_r <= digOutOver_r || (slotClass == CLS_DIGITAL);
        end else begin
          digOut_r <= digOut_r + {8'h00, slotOutSize};
        end
      end
    end
  end

  // Result registers, one entry per placed slot.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      resultValid <= 1'b0;
      resultSlot <= '0;
      resultInAddr <= '0;
      resultOutAddr <= '0;
    end else begin
      resultValid <= (state_r == ST_PLACE);
      if (state_r == ST_PLACE) begin
        resultSlot <= slot_r;
        resultInAddr <= inBase;
        resultOutAddr <= outBase;
      end
    end
  end

  // Image size, preset to the default and changed by parameter load.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      imageLast_r <= IMAGE_LAST_RST;
    end else if (imageLastLoad) begin
      imageLast_r <= (imageLastCfg > 16'h00FF) ? 16'h00FF : imageLastCfg;
    end
  end

  // Periphery input bytes come from outside, so they are synchronised.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      periInSync1_r <= 8'h00;
      periInSync2_r <= 8'h00;
    end else begin
      periInSync1_r <= periInData;
      periInSync2_r <= periInSync1_r;
    end
  end

  assign slotIdx = slot_r;
  assign allocDone = (state_r == ST_DONE);
  assign allocError = (state_r == ST_ERROR);

  assign img.cycleEnd = cycleEnd;
  assign img.imageLast = imageLast_r;
  assign img.swWe = swWe;
  assign img.swOut = swOut;
  assign img.swIdx = swIdx;
  assign img.swWdata = swWdata;
  assign img.periInData = periInSync2_r;

  paa_image u_image (
    .clock(clock),
    .arst_n(arst_n),
    .img(img)
  );

  assign swRdata = img.swRdata;
  assign refreshBusy = img.refreshBusy;
  assign periIdx = img.refreshIdx;
  assign periOutData = img.periOutData;
  assign periOutWe = img.periOutWe;

  // Checks on starting and stepping the allocation walk.
  module_limit_a: assert property (@(posedge clock) disable iff (!arst_n)
    (start && state_r != ST_FETCH && state_r != ST_PLACE && moduleCount > MAX_MODULES)
      |=> allocError)
    else $error("too many modules not refused");
  module_accept_a: assert property (@(posedge clock) disable iff (!arst_n)
    (start && state_r != ST_FETCH && state_r != ST_PLACE && moduleCount <= MAX_MODULES)
      |=> !allocError && state_r == ST_FETCH)
    else $error("allowed module count refused");
  first_slot_a: assert property (@(posedge clock) disable iff (!arst_n)
    (start && state_r != ST_FETCH && state_r != ST_PLACE) |=> slot_r == FIRST_SLOT)
    else $error("allocation does not start at slot one");
  slot_step_a: assert property (@(posedge clock) disable iff (!arst_n)
    (state_r == ST_PLACE) |=> slot_r == $past(slot_r) + 7'h01)
    else $error("slot not advanced in plug order");
  done_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
    (allocDone && !start) |=> allocDone)
    else $error("finished walk left without a new start");

  // Checks on placement of each span.
  analog_even_a: assert property (@(posedge clock) disable iff (!arst_n)
    (state_r == ST_PLACE && !userCfgValid && slotClass == CLS_ANALOG)
      |=> !resultInAddr[0] && !resultOutAddr[0])
    else $error("analog span on odd address");
  other_base_a: assert property (@(posedge clock) disable iff (!arst_n)
    (state_r == ST_PLACE && !userCfgValid && slotClass != CLS_DIGITAL)
      |=> resultInAddr >= OTHER_BASE && resultOutAddr >= OTHER_BASE)
    else $error("non-digital span below shared base");
  digital_pack_a: assert property (@(posedge clock) disable iff (!arst_n)
    (state_r == ST_PLACE && !userCfgValid && !useOthIn && slotInSize != 8'h00)
      |=> digIn_r == $past(digIn_r) + {8'h00, $past(slotInSize)})
    else $error("digital input pointer not advanced by span");
  digital_out_pack_a: assert property (@(posedge clock) disable iff (!arst_n)
    (state_r == ST_PLACE && !userCfgValid && !useOthOut && slotOutSize != 8'h00)
      |=> digOut_r == $past(digOut_r) + {8'h00, $past(slotOutSize)})
    else $error("digital output pointer not advanced by span");
  other_pack_a: assert property (@(posedge clock) disable iff (!arst_n)
    (state_r == ST_PLACE && !userCfgValid && useOthIn && slotInSize != 8'h00)
      |=> othIn_r == resultInAddr + {8'h00, $past(slotInSize)})
    else $error("shared input pointer not advanced by span");
  other_out_pack_a: assert property (@(posedge clock) disable iff (!arst_n)
    (state_r == ST_PLACE && !userCfgValid && useOthOut && slotOutSize != 8'h00)
      |=> othOut_r == resultOutAddr + {8'h00, $past(slotOutSize)})
    else $error("shared output pointer not advanced by span");
  digital_fit_a: assert property (@(posedge clock) disable iff (!arst_n)
    (state_r == ST_PLACE && !userCfgValid && slotClass == CLS_DIGITAL && !useOthIn)
      |=> resultInAddr + {8'h00, $past(slotInSize)} <= OTHER_BASE)
    else $error("digital span passes shared base");
  spill_sticky_a: assert property (@(posedge clock) disable iff (!arst_n)
    (state_r == ST_PLACE && !userCfgValid && digInOver_r)
      |=> resultInAddr >= OTHER_BASE)
    else $error("digital span returned below shared base after spill");
  user_addr_a: assert property (@(posedge clock) disable iff (!arst_n)
    (state_r == ST_PLACE && userCfgValid)
      |=> resultInAddr == $past(userInAddr) && resultOutAddr == $past(userOutAddr))
    else $error("user address not used");
  user_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
    (state_r == ST_PLACE && userCfgValid)
      |=> $stable(digIn_r) && $stable(digOut_r) && $stable(othIn_r) && $stable(othOut_r))
    else $error("pointer moved under user configuration");

  // Checks on image size and refresh.
  image_default_a: assert property (@(posedge clock) disable iff (!arst_n)
    $rose(arst_n) |-> imageLast_r == IMAGE_LAST_RST)
    else $error("image size default wrong");
  image_load_a: assert property (@(posedge clock) disable iff (!arst_n)
    (imageLastLoad && imageLastCfg <= 16'h00FF) |=> imageLast_r == $past(imageLastCfg))
    else $error("image size not taken from parameter");
  refresh_start_a: assert property (@(posedge clock) disable iff (!arst_n)
    (cycleEnd && !refreshBusy) |=> refreshBusy && periIdx == 8'h00)
    else $error("image refresh not started at cycle end");
  refresh_walk_a: assert property (@(posedge clock) disable iff (!arst_n)
    (refreshBusy && {8'h00, periIdx} < imageLast_r)
      |=> refreshBusy && periIdx == $past(periIdx) + 8'h01)
    else $error("image refresh skipped a byte");
  refresh_end_a: assert property (@(posedge clock) disable iff (!arst_n)
    (refreshBusy && {8'h00, periIdx} >= imageLast_r) |=> !refreshBusy)
    else $error("image refresh ran past the last byte");
endmodule : paa_allocator

// ### hw/paa_pkg.sv
// Package with constants and types for the periphery address allocator.
package paa_pkg;
  localparam int ADDR_W = 16;
  localparam int SLOT_W = 7;
  localparam int SIZE_W = 8;
  localparam logic [ADDR_W-1:0] DIGITAL_BASE = 16'h0000;
  localparam logic [ADDR_W-1:0] OTHER_BASE = 16'h0100;
  localparam logic [SLOT_W-1:0] MAX_MODULES = 7'h40;
  localparam logic [SLOT_W-1:0] FIRST_SLOT = 7'h01;
  localparam logic [ADDR_W-1:0] IMAGE_LAST_RST = 16'h007F;
  localparam int IMAGE_DEPTH = 256;
  localparam int IMAGE_IDX_W = 8;

  // Module classes reported by each slot.
  typedef enum logic [1:0] {
    CLS_DIGITAL = 2'b00,
    CLS_ANALOG = 2'b01,
    CLS_SPECIAL = 2'b10,
    CLS_OTHER = 2'b11
  } paa_class_t;

  // Allocator states.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_FETCH = 3'b001,
    ST_PLACE = 3'b010,
    ST_DONE = 3'b011,
    ST_ERROR = 3'b100
  } paa_state_t;
endpackage : paa_pkg

// ### hw/paa_image_if.sv
// Interface between the allocator core and its process image store.
`timescale 1ns/100ps
interface paa_image_if;
  import paa_pkg::*;
  logic cycleEnd;
  logic [ADDR_W-1:0] imageLast;
  logic ioBusy;
  logic refreshBusy;
  logic [IMAGE_IDX_W-1:0] refreshIdx;
  logic swWe;
  logic swOut;
  logic [IMAGE_IDX_W-1:0] swIdx;
  logic [7:0] swWdata;
  logic [7:0] swRdata;
  logic [7:0] periInData;
  logic [7:0] periOutData;
  logic periOutWe;
  modport core (output cycleEnd, imageLast, swWe, swOut, swIdx, swWdata, periInData,
    input refreshBusy, refreshIdx, swRdata, periOutData, periOutWe, ioBusy);
  modport image (input cycleEnd, imageLast, swWe, swOut, swIdx, swWdata, periInData,
    output refreshBusy, refreshIdx, swRdata, periOutData, periOutWe, ioBusy);
endinterface : paa_image_if

// ### hw/paa_image.sv
// Input and output process images with end-of-cycle refresh.
`timescale 1ns/100ps
module paa_image
  import paa_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic arst_n,
  // Link to the core.
  paa_image_if.image img
);
  logic [7:0] inImage_r [IMAGE_DEPTH];
  logic [7:0] outImage_r [IMAGE_DEPTH];
  logic busy_r;
  logic [IMAGE_IDX_W-1:0] idx_r;

  // Refresh walk over the image, started at a cycle end that comes while no walk is running.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      busy_r <= 1'b0;
      idx_r <= '0;
    end else if (!busy_r && img.cycleEnd) begin
      busy_r <= 1'b1;
      idx_r <= '0;
    end else if (busy_r) begin
      if ({8'h00, idx_r} >= img.imageLast) begin
        busy_r <= 1'b0;
      end else begin
        idx_r <= idx_r + 8'h01;
      end
    end
  end

  // Image storage: refresh copies periphery in and image out, software uses the rest.
  always_ff @(posedge clock) begin
    if (busy_r) begin
      inImage_r[idx_r] <= img.periInData;
    end else if (img.swWe && !img.swOut) begin
      inImage_r[img.swIdx] <= img.swWdata;
    end
    if (img.swWe && img.swOut && !busy_r) begin
      outImage_r[img.swIdx] <= img.swWdata;
    end
  end

  assign img.refreshBusy = busy_r;
  assign img.ioBusy = busy_r;
  assign img.refreshIdx = idx_r;
  assign img.periOutData = outImage_r[idx_r];
  assign img.periOutWe = busy_r;
  assign img.swRdata = img.swOut ? outImage_r[img.swIdx] : inImage_r[img.swIdx];
endmodule : paa_image

// ### tb/paa_backplane_model.sv
// Model of the modules plugged on the backplane bus.
`timescale 1ns/100ps
module paa_backplane_model
  import paa_pkg::*;
(
  // Clock.
  input wire logic clock,
  // Slot description.
  input wire logic [SLOT_W-1:0] slotIdx,
  output paa_class_t slotClass,
  output logic [SIZE_W-1:0] slotInSize,
  output logic [SIZE_W-1:0] slotOutSize,
  output logic [ADDR_W-1:0] userInAddr,
  output logic [ADDR_W-1:0] userOutAddr,
  // Periphery bytes.
  input wire logic [IMAGE_IDX_W-1:0] periIdx,
  output logic [7:0] periInData,
  input wire logic [7:0] periOutData,
  input wire logic periOutWe
);
  paa_class_t cls [0:127];
  logic [SIZE_W-1:0] inSz [0:127];
  logic [SIZE_W-1:0] outSz [0:127];
  logic [7:0] inVal = 8'h00;
  logic [7:0] outSeen [0:255];
  // Empty slots describe a module with no process data.
  initial begin
    for (int i = 0; i < 128; i++) begin
      cls[i] = CLS_OTHER;
      inSz[i] = 8'h00;
      outSz[i] = 8'h00;
    end
  end
  // The addressed module answers its descriptor at once.
  assign slotClass = cls[slotIdx];
  assign slotInSize = inSz[slotIdx];
  assign slotOutSize = outSz[slotIdx];
  assign userInAddr = {1'b0, slotIdx, 8'h10};
  assign userOutAddr = {1'b1, slotIdx, 8'h20};
  assign periInData = inVal;
  // Output bytes are latched by the modules as they are refreshed.
  always @(posedge clock) begin
    if (periOutWe) begin
      outSeen[periIdx] <= periOutData;
    end
  end
endmodule : paa_backplane_model

// ### tb/tb_top.sv
// Self-checking testbench for the periphery address allocator.
`timescale 1ns/100ps
module tb_top;
  import paa_pkg::*;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic start = 1'b0;
  logic userCfgValid = 1'b0;
  logic [SLOT_W-1:0] moduleCount = 7'h00;
  logic [ADDR_W-1:0] imageLastCfg = 16'h0000;
  logic imageLastLoad = 1'b0;
  logic cycleEnd = 1'b0;
  logic swWe = 1'b0;
  logic swOut = 1'b0;
  logic [IMAGE_IDX_W-1:0] swIdx = 8'h00;
  logic [7:0] swWdata = 8'h00;
  logic [SLOT_W-1:0] slotIdx, resultSlot;
  paa_class_t slotClass;
  logic [SIZE_W-1:0] slotInSize, slotOutSize;
  logic [ADDR_W-1:0] userInAddr, userOutAddr, resultInAddr, resultOutAddr;
  logic resultValid, allocDone, allocError, refreshBusy, periOutWe;
  logic [7:0] swRdata, periInData, periOutData;
  logic [IMAGE_IDX_W-1:0] periIdx;
  int nMismatch = 0;
  int samplesChecked = 0;
  // Clock of 40 ns period.
  always #20 clock = ~clock;
  paa_allocator dut (.clock, .arst_n, .start, .userCfgValid, .moduleCount, .imageLastCfg,
    .imageLastLoad, .slotIdx, .slotClass, .slotInSize, .slotOutSize, .userInAddr,
    .userOutAddr, .resultValid, .resultSlot, .resultInAddr, .resultOutAddr, .allocDone,
    .allocError, .cycleEnd, .swWe, .swOut, .swIdx, .swWdata, .swRdata, .refreshBusy,
    .periIdx, .periInData, .periOutData, .periOutWe);
  paa_backplane_model bp (.clock, .slotIdx, .slotClass, .slotInSize, .slotOutSize,
    .userInAddr, .userOutAddr, .periIdx, .periInData, .periOutData, .periOutWe);
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    samplesChecked++;
    if (got !== exp) begin
      nMismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // Reference placement with one digital and one shared pointer per direction.
  function automatic logic [15:0] place(input paa_class_t c, input logic [7:0] s,
      inout logic [15:0] d, inout logic [15:0] o, inout logic ov);
    if (c == CLS_DIGITAL && !ov && d + s <= OTHER_BASE) begin
      place = d;
      d += s;
    end else begin
      if (c == CLS_DIGITAL) ov = 1'b1;
      if (c == CLS_ANALOG) o = (o + 16'h0001) & 16'hFFFE;
      place = o;
      o += s;
    end
  endfunction : place
  task automatic setSlot(input int i, input logic [1:0] c, input logic [7:0] ni,
      input logic [7:0] no);
    bp.cls[i] = paa_class_t'(c);
    bp.inSz[i] = ni;
    bp.outSz[i] = no;
  endtask : setSlot
  // Walks all slots and compares every nonzero span of each result with the reference placement, or with the user addresses when user is set.
  task automatic runAlloc(input logic [6:0] cnt, input logic user);
    logic [15:0] dI, dO, oI, oO;
    logic ovI, ovO;
    int n;
    logic [6:0] s;
    dI = DIGITAL_BASE;
    dO = DIGITAL_BASE;
    oI = OTHER_BASE;
    oO = OTHER_BASE;
    ovI = 1'b0;
    ovO = 1'b0;
    n = 0;
    @(posedge clock);
    moduleCount <= cnt;
    userCfgValid <= user;
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
    #1;
    for (int k = 0; k < 400 && allocDone !== 1'b1; k++) begin
      @(posedge clock);
      #1;
      if (resultValid === 1'b1) begin
        n++;
        s = resultSlot;
        check("slot", 16'(n), 16'(s));
        if (user) begin
          check("user in", {1'b0, s, 8'h10}, resultInAddr);
          check("user out", {1'b1, s, 8'h20}, resultOutAddr);
        end else begin
          if (bp.inSz[s] != 8'h00) begin
            check("in", place(bp.cls[s], bp.inSz[s], dI, oI, ovI), resultInAddr);
          end
          if (bp.outSz[s] != 8'h00) begin
            check("out", place(bp.cls[s], bp.outSz[s], dO, oO, ovO), resultOutAddr);
          end
        end
      end
    end
    check("done", 16'h0001, {15'h0000, allocDone});
    check("count", 16'(cnt), 16'(n));
  endtask : runAlloc
  // Plug order of the worked example, plus special, analog and other modules.
  task automatic testExample();
    logic [1:0] c [1:12] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h1, 2'h1, 2'h0, 2'h0, 2'h2,
      2'h1, 2'h3};
    logic [7:0] ni [1:12] = '{8'h01, 8'h01, 8'h00, 8'h04, 8'h00, 8'h08, 8'h00, 8'h00,
      8'h01, 8'h03, 8'h02, 8'h00};
    logic [7:0] no [1:12] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h04, 8'h00, 8'h08, 8'h01,
      8'h00, 8'h00, 8'h00, 8'h02};
    for (int i = 1; i <= 12; i++) setSlot(i, c[i], ni[i], no[i]);
    runAlloc(7'h0C, 1'b0);
    runAlloc(7'h0C, 1'b1);
  endtask : testExample
  // Digital spans fill exactly to 256, then spill into the shared area.
  task automatic testOverflow();
    setSlot(1, 2'h0, 8'hC8, 8'h00);
    setSlot(2, 2'h1, 8'h04, 8'h04);
    setSlot(3, 2'h0, 8'h38, 8'h00);
    setSlot(4, 2'h0, 8'h01, 8'h00);
    setSlot(5, 2'h0, 8'h02, 8'h01);
    runAlloc(7'h05, 1'b0);
  endtask : testOverflow
  // Sixty-four modules are accepted, sixty-five are refused.
  task automatic testLimit();
    for (int i = 1; i <= 64; i++) setSlot(i, 2'h0, 8'h01, 8'h00);
    runAlloc(MAX_MODULES, 1'b0);
    @(posedge clock);
    moduleCount <= MAX_MODULES + 7'h01;
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
    repeat (4) @(posedge clock);
    #1;
    check("error", 16'h0001, {15'h0000, allocError});
  endtask : testLimit
  // Starts one refresh and counts its busy cycles.
  task automatic runRefresh(input logic [7:0] val, output int busy);
    bp.inVal = val;
    repeat (3) @(posedge clock);
    cycleEnd <= 1'b1;
    @(posedge clock);
    cycleEnd <= 1'b0;
    busy = 0;
    #1;
    while (refreshBusy === 1'b1 && busy < 400) begin
      @(posedge clock);
      #1;
      busy++;
    end
  endtask : runRefresh
  task automatic readImage(input logic o, input logic [7:0] i, input logic [7:0] exp);
    @(posedge clock);
    swOut <= o;
    swIdx <= i;
    @(posedge clock);
    #1;
    check("image", {8'h00, exp}, {8'h00, swRdata});
  endtask : readImage
  // Software writes, end-of-cycle refresh and a shortened image.
  task automatic testImage();
    int busy;
    @(posedge clock);
    swWe <= 1'b1;
    swOut <= 1'b1;
    swIdx <= 8'h05;
    swWdata <= 8'hA5;
    @(posedge clock);
    swWe <= 1'b0;
    readImage(1'b1, 8'h05, 8'hA5);
    runRefresh(8'h3C, busy);
    check("busy", IMAGE_LAST_RST + 16'h0001, 16'(busy));
    check("out byte", 16'h00A5, {8'h00, bp.outSeen[5]});
    readImage(1'b0, 8'h7F, 8'h3C);
    @(posedge clock);
    imageLastCfg <= 16'h0003;
    imageLastLoad <= 1'b1;
    @(posedge clock);
    imageLastLoad <= 1'b0;
    runRefresh(8'hC3, busy);
    check("busy", 16'h0004, 16'(busy));
    readImage(1'b0, 8'h03, 8'hC3);
  endtask : testImage
  task automatic summarize();
    $display("Comparisons %0d mismatches %0d", samplesChecked, nMismatch);
    if (nMismatch == 0 && samplesChecked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize
  // Main sequence after six cycles of reset.
  initial begin
    repeat (6) @(posedge clock);
    arst_n <= 1'b1;
    testExample();
    testOverflow();
    testLimit();
    testImage();
    summarize();
  end
  // Watchdog well beyond the few hundred cycles the tests need.
  initial begin
    repeat (20000) @(posedge clock);
    nMismatch++;
    summarize();
  end
endmodule : tb_top
